// *** rtl/tw_bus_unit.sv ***
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`include "tw_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tw_bus_unit #(
    parameter int ADDR_W = 8
) (
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              p_scl_i,
    output logic                   p_scl_o,
    output logic                   p_scl_oe,
    input  wire logic              p_sda_i,
    output logic                   p_sda_o,
    output logic                   p_sda_oe,
    input  wire logic              s_scl_i,
    output logic                   s_scl_o,
    output logic                   s_scl_oe,
    input  wire logic              s_sda_i,
    output logic                   s_sda_o,
    output logic                   s_sda_oe
);

    tw_pkg::tw_state_t st;
    tw_pkg::tw_state_t next_st;

    logic scl_s, sda_s, scl_q, sda_q;
    logic scl_r, scl_f, s_start, s_stop;
    logic p_start, p_stop, sw_force;
    logic [17:0] tlimit;

    function automatic logic tw_hit(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= `TW_OFS_SDATA);
    endfunction

    function automatic logic [7:0] tw_read(input tw_pkg::tw_state_t s, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `TW_OFS_CTRLA: v = s.ctrl_a;
            `TW_OFS_DUAL:  v = {7'h00, s.dual_en};
            `TW_OFS_BAUD:  v = s.baud;
            `TW_OFS_MCTRL: v = {4'h0, s.tout, 1'b0, s.m_en};
            `TW_OFS_MSTAT: v = {6'h00, s.bstate};
            `TW_OFS_SADDR: v = {s.saddr, 1'b0};
            `TW_OFS_SCTRL: v = {7'h00, s.s_en};
            `TW_OFS_SSTAT: v = {1'b0, s.st_stop, s.st_rep, s.st_nack, s.st_txfull, s.st_rxrdy, s.st_dir, s.st_match};
            `TW_OFS_SDATA: v = s.rxd;
            default:       v = 8'h00;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        // Slave pins: secondary pair in dual mode, primary otherwise
        scl_s = st.dual_en ? st.s2[1] : st.s2[3];
        sda_s = st.dual_en ? st.s2[0] : st.s2[2];
        scl_q = st.dual_en ? st.s3[1] : st.s3[3];
        sda_q = st.dual_en ? st.s3[0] : st.s3[2];
        scl_r = scl_s & ~scl_q;
        scl_f = ~scl_s & scl_q;
        s_start = scl_s & scl_q & ~sda_s & sda_q;
        s_stop  = scl_s & scl_q & sda_s & ~sda_q;
        p_start = st.s2[3] & st.s3[3] & ~st.s2[2] & st.s3[2];
        p_stop  = st.s2[3] & st.s3[3] & st.s2[2] & ~st.s3[2];
        sw_force = 1'b0;
        tlimit = 18'({st.baud, 4'h0}) << st.tout;

        next_st.s1 = {p_scl_i, p_sda_i, s_scl_i, s_sda_i};
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;

        // Register bus, write path
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_got = 1'b1;
            next_st.aw_a = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_got = 1'b1;
            next_st.wd = s_axi_wdata[7:0];
            next_st.wen = s_axi_wstrb[0];
        end
        if (next_st.aw_got && next_st.w_got && !st.bvalid) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = tw_hit(next_st.aw_a) ? `TW_RESP_OK : `TW_RESP_ERR;
            if (next_st.wen) begin
                case (next_st.aw_a)
                    `TW_OFS_CTRLA: next_st.ctrl_a = next_st.wd;
                    `TW_OFS_DUAL:  next_st.dual_en = next_st.wd[`TW_EN_BIT];
                    `TW_OFS_BAUD:  next_st.baud = next_st.wd;
                    `TW_OFS_MCTRL: begin
                        next_st.m_en = next_st.wd[`TW_EN_BIT];
                        next_st.tout = next_st.wd[`TW_TOUT_LSB+:2];
                    end
                    `TW_OFS_MSTAT: sw_force = (next_st.wd[1:0] == `TW_BS_FORCE);
                    `TW_OFS_SADDR: next_st.saddr = next_st.wd[7:1];
                    `TW_OFS_SCTRL: next_st.s_en = next_st.wd[`TW_EN_BIT];
                    `TW_OFS_SSTAT: begin
                        next_st.st_match = st.st_match & ~next_st.wd[`TW_SS_MATCH];
                        next_st.st_nack = st.st_nack & ~next_st.wd[`TW_SS_NACK];
                        next_st.st_rep = st.st_rep & ~next_st.wd[`TW_SS_REP];
                        next_st.st_stop = st.st_stop & ~next_st.wd[`TW_SS_STOP];
                    end
                    `TW_OFS_SDATA: begin
                        next_st.txd = next_st.wd;
                        next_st.st_txfull = 1'b1;
                    end
                    default: ;
                endcase
            end
        end

        // Register bus, read path; reading data frees the receive byte
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = {24'h000000, tw_read(st, s_axi_araddr[7:0])};
            next_st.rresp = tw_hit(s_axi_araddr[7:0]) ? `TW_RESP_OK : `TW_RESP_ERR;
            if (s_axi_araddr[7:0] == `TW_OFS_SDATA) begin
                next_st.st_rxrdy = 1'b0;
            end
        end
        next_st.awready = !next_st.aw_got && !next_st.bvalid;
        next_st.wready = !next_st.w_got && !next_st.bvalid;
        next_st.arready = !next_st.rvalid;

        ////////////////////////////////////////////////////////////////////////////////
        // Bus state monitor on the primary pair
        if (!next_st.m_en) begin
            next_st.bstate = tw_pkg::TW_BS_UNKNOWN;
            next_st.tcnt = 18'h00000;
        end else begin
            if (sw_force) begin
                next_st.bstate = tw_pkg::TW_BS_IDLE;
            end
            if (st.s2[3] && st.s2[2] && st.tout != 2'h0) begin
                next_st.tcnt = st.tcnt + 18'h00001;
                if (st.tcnt >= tlimit) begin
                    next_st.bstate = tw_pkg::TW_BS_IDLE;
                    next_st.tcnt = 18'h00000;
                end
            end else begin
                next_st.tcnt = 18'h00000;
            end
            if (p_stop) begin
                next_st.bstate = tw_pkg::TW_BS_IDLE;
            end else if (p_start && st.bstate == tw_pkg::TW_BS_IDLE) begin
                next_st.bstate = tw_pkg::TW_BS_BUSY;
            end
        end

        ////////////////////////////////////////////////////////////////////////////////
        // Slave engine
        if (!st.s_en) begin
            next_st.sst = tw_pkg::TW_S_WAIT;
            next_st.sda_oe = 1'b0;
            next_st.scl_oe = 1'b0;
            next_st.in_frame = 1'b0;
        end else if (s_start) begin
            if (st.in_frame) begin
                next_st.st_rep = 1'b1;
            end
            next_st.in_frame = 1'b1;
            next_st.sst = tw_pkg::TW_S_ADDR;
            next_st.cnt = 4'h0;
            next_st.sda_oe = 1'b0;
            next_st.scl_oe = 1'b0;
        end else if (s_stop) begin
            next_st.in_frame = 1'b0;
            next_st.st_stop = 1'b1;
            next_st.sst = tw_pkg::TW_S_WAIT;
            next_st.sda_oe = 1'b0;
            next_st.scl_oe = 1'b0;
        end else begin
            case (st.sst)
                tw_pkg::TW_S_ADDR, tw_pkg::TW_S_RX: begin
                    if (scl_r) begin
                        next_st.shift = {st.shift[6:0], sda_s};
                        next_st.cnt = st.cnt + 4'h1;
                    end
                    if (scl_f && st.cnt == `TW_BITS_BYTE) begin
                        if (st.sst == tw_pkg::TW_S_RX) begin
                            next_st.rxd = st.shift;
                            next_st.st_rxrdy = 1'b1;
                            next_st.sda_oe = 1'b1;
                            next_st.sst = tw_pkg::TW_S_RACK;
                        end else if (st.shift[7:1] == st.saddr) begin
                            next_st.st_match = 1'b1;
                            next_st.st_dir = st.shift[0];
                            next_st.sda_oe = 1'b1;
                            next_st.sst = tw_pkg::TW_S_AACK;
                        end else begin
                            next_st.sst = tw_pkg::TW_S_WAIT;
                        end
                    end
                end
                tw_pkg::TW_S_AACK, tw_pkg::TW_S_RACK, tw_pkg::TW_S_TACK: begin
                    if (scl_r && st.sst == tw_pkg::TW_S_TACK) begin
                        next_st.st_nack = sda_s;
                    end
                    // Act on the falling clock, or keep checking while stretching
                    if (scl_f || st.scl_oe) begin
                        next_st.sda_oe = 1'b0;
                        if (st.sst == tw_pkg::TW_S_TACK && st.st_nack) begin
                            next_st.scl_oe = 1'b0;
                            next_st.sst = tw_pkg::TW_S_WAIT;
                        end else if (st.st_dir) begin
                            if (st.st_txfull) begin
                                next_st.shift = st.txd;
                                next_st.st_txfull = 1'b0;
                                next_st.sda_oe = ~st.txd[7];
                                next_st.cnt = 4'h0;
                                next_st.scl_oe = 1'b0;
                                next_st.sst = tw_pkg::TW_S_TX;
                            end else begin
                                next_st.scl_oe = 1'b1;
                            end
                        end else if (next_st.st_rxrdy) begin
                            next_st.scl_oe = 1'b1;
                        end else begin
                            next_st.scl_oe = 1'b0;
                            next_st.cnt = 4'h0;
                            next_st.sst = tw_pkg::TW_S_RX;
                        end
                    end
                end
                tw_pkg::TW_S_TX: begin
                    if (scl_r) begin
                        next_st.cnt = st.cnt + 4'h1;
                    end
                    if (scl_f) begin
                        if (st.cnt == `TW_BITS_BYTE) begin
                            next_st.sda_oe = 1'b0;
                            next_st.sst = tw_pkg::TW_S_TACK;
                        end else begin
                            next_st.shift = {st.shift[6:0], 1'b0};
                            next_st.sda_oe = ~st.shift[6];
                        end
                    end
                end
                default: begin
                    next_st.sda_oe = 1'b0;
                    next_st.scl_oe = 1'b0;
                end
            endcase
        end

        // Open-drain pins: only ever pulled low or released
        next_st.drv = 1'b0;
        next_st.p_scl_oe = next_st.scl_oe & ~next_st.dual_en;
        next_st.p_sda_oe = next_st.sda_oe & ~next_st.dual_en;
        next_st.s_scl_oe = next_st.scl_oe & next_st.dual_en;
        next_st.s_sda_oe = next_st.sda_oe & next_st.dual_en;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready  = st.wready;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rresp   = st.rresp;
    assign s_axi_rdata   = st.rdata;
    assign p_scl_o  = st.drv;
    assign p_sda_o  = st.drv;
    assign s_scl_o  = st.drv;
    assign s_sda_o  = st.drv;
    assign p_scl_oe = st.p_scl_oe;
    assign p_sda_oe = st.p_sda_oe;
    assign s_scl_oe = st.s_scl_oe;
    assign s_sda_oe = st.s_sda_oe;

    ////////////////////////////////////////////////////////////////////////////////
    property p_stop_idle;
        @(posedge ref_clk) disable iff (!reset_n)
        (next_st.m_en && p_stop) |=> (st.bstate == tw_pkg::TW_BS_IDLE);
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle bus");

    property p_off_unknown;
        @(posedge ref_clk) disable iff (!reset_n)
        !st.m_en |-> (st.bstate == tw_pkg::TW_BS_UNKNOWN);
    endproperty
    a_off_unknown: assert property (p_off_unknown) else $error("disabled master not unknown");

    property p_start_addr;
        @(posedge ref_clk) disable iff (!reset_n)
        (st.s_en && s_start) |=> (st.sst == tw_pkg::TW_S_ADDR && st.cnt == 4'h0 && !st.sda_oe);
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("start not taken");

    property p_rep_start;
        @(posedge ref_clk) disable iff (!reset_n)
        (st.s_en && s_start && st.in_frame) |=> st.st_rep;
    endproperty
    a_rep_start: assert property (p_rep_start) else $error("repeated start missed");

    property p_sda_low_clk;
        @(posedge ref_clk) disable iff (!reset_n)
        ($changed(st.sda_oe) && $past(st.s_en) && st.s_en && !$past(s_start) && !$past(s_stop))
            |-> !$past(scl_s);
    endproperty
    a_sda_low_clk: assert property (p_sda_low_clk) else $error("data moved with clock high");

    property p_ack_match;
        @(posedge ref_clk) disable iff (!reset_n)
        (st.s_en && !s_start && !s_stop && st.sst == tw_pkg::TW_S_ADDR && scl_f && st.cnt == 4'h8
            && st.shift[7:1] == st.saddr) |=> (st.sda_oe && st.sst == tw_pkg::TW_S_AACK) ##1 st.p_sda_oe | st.s_sda_oe;
    endproperty
    a_ack_match: assert property (p_ack_match) else $error("address not acknowledged");

    property p_nomatch;
        @(posedge ref_clk) disable iff (!reset_n)
        (st.s_en && !s_start && !s_stop && st.sst == tw_pkg::TW_S_ADDR && scl_f && st.cnt == 4'h8
            && st.shift[7:1] != st.saddr) |=> (st.sst == tw_pkg::TW_S_WAIT && !st.sda_oe && !st.scl_oe);
    endproperty
    a_nomatch: assert property (p_nomatch) else $error("foreign address not released");

    property p_stretch;
        @(posedge ref_clk) disable iff (!reset_n)
        st.scl_oe |-> (st.sst inside {tw_pkg::TW_S_AACK, tw_pkg::TW_S_RACK, tw_pkg::TW_S_TACK});
    endproperty
    a_stretch: assert property (p_stretch) else $error("clock held outside acknowledge");

    property p_pins;
        @(posedge ref_clk) disable iff (!reset_n)
        !p_scl_o && !p_sda_o && !s_scl_o && !s_sda_o && !(s_scl_oe && !st.dual_en) && !(p_scl_oe && st.dual_en);
    endproperty
    a_pins: assert property (p_pins) else $error("pin driven high or wrong pair");

    property p_bhold;
        @(posedge ref_clk) disable iff (!reset_n)
        (st.bvalid && !s_axi_bready) |=> (st.bvalid && $stable(st.bresp));
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");

endmodule // tw_bus_unit

`default_nettype wire

// *** rtl/tw_defines.svh ***
`ifndef TW_DEFINES_SVH
`define TW_DEFINES_SVH

// Register byte offsets
`define TW_OFS_CTRLA  8'h00
`define TW_OFS_DUAL   8'h04
`define TW_OFS_BAUD   8'h08
`define TW_OFS_MCTRL  8'h0C
`define TW_OFS_MSTAT  8'h10
`define TW_OFS_SADDR  8'h14
`define TW_OFS_SCTRL  8'h18
`define TW_OFS_SSTAT  8'h1C
`define TW_OFS_SDATA  8'h20

// Field positions
`define TW_EN_BIT     0
`define TW_TOUT_LSB   2
`define TW_SS_MATCH   0
`define TW_SS_DIR     1
`define TW_SS_RXRDY   2
`define TW_SS_TXFULL  3
`define TW_SS_NACK    4
`define TW_SS_REP     5
`define TW_SS_STOP    6

// Reset values and codes
`define TW_RST_BYTE   8'h00
`define TW_BS_FORCE   2'h1
`define TW_RESP_OK    2'h0
`define TW_RESP_ERR   2'h2

// Timing: inactive-bus limit is baud setting scaled by this shift, then shifted left by the MCTRL timeout field
`define TW_TOUT_SHIFT 4
`define TW_BITS_BYTE  4'h8

`endif

// *** rtl/tw_pkg.sv ***
package tw_pkg;

    typedef enum logic [1:0] {
        TW_BS_UNKNOWN = 2'h0,
        TW_BS_IDLE    = 2'h1,
        TW_BS_OWNER   = 2'h2,
        TW_BS_BUSY    = 2'h3
    } tw_bus_state_t;

    typedef enum logic [2:0] {
        TW_S_WAIT = 3'h0,
        TW_S_ADDR = 3'h1,
        TW_S_AACK = 3'h3,
        TW_S_RX   = 3'h2,
        TW_S_RACK = 3'h6,
        TW_S_TX   = 3'h7,
        TW_S_TACK = 3'h5
    } tw_slv_state_t;

    typedef struct packed {
        logic [7:0]    ctrl_a;
        logic          dual_en;
        logic [7:0]    baud;
        logic          m_en;
        logic [1:0]    tout;
        tw_bus_state_t bstate;
        logic [17:0]   tcnt;
        logic [6:0]    saddr;
        logic          s_en;
        logic          st_match;
        logic          st_dir;
        logic          st_rxrdy;
        logic          st_txfull;
        logic          st_nack;
        logic          st_rep;
        logic          st_stop;
        logic [7:0]    rxd;
        logic [7:0]    txd;
        logic [7:0]    shift;
        logic [3:0]    cnt;
        tw_slv_state_t sst;
        logic          in_frame;
        logic [3:0]    s1;
        logic [3:0]    s2;
        logic [3:0]    s3;
        logic          scl_oe;
        logic          sda_oe;
        logic          p_scl_oe;
        logic          p_sda_oe;
        logic          s_scl_oe;
        logic          s_sda_oe;
        logic          drv;
        logic          aw_got;
        logic          w_got;
        logic [7:0]    aw_a;
        logic [7:0]    wd;
        logic          wen;
        logic          awready;
        logic          wready;
        logic          bvalid;
        logic [1:0]    bresp;
        logic          arready;
        logic          rvalid;
        logic [1:0]    rresp;
        logic [31:0]   rdata;
    } tw_state_t;

endpackage

// *** tb/tw_bus_unit_bench.sv ***
`include "tw_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tw_bus_unit_bench;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  aw_a    = 8'h00;
    logic [7:0]  ar_a    = 8'h00;
    logic [31:0] wd      = 32'h0;
    logic        awv     = 1'b0;
    logic        wv      = 1'b0;
    logic        arv     = 1'b0;
    logic        awr, wr_r, bv, arr, rv;
    logic [1:0]  br, rr;
    logic [31:0] rdat;
    logic        p_scl_oe, p_sda_oe, s_scl_oe, s_sda_oe, m_scl, m_sda;
    wire         scl = !(p_scl_oe || m_scl);
    wire         sda = !(p_sda_oe || m_sda);
    logic        m2_scl, m2_sda;
    wire         s_scl = !(s_scl_oe || m2_scl);
    wire         s_sda = !(s_sda_oe || m2_sda);
    int          error_cnt  = 0;
    int          num_checks = 0;
    int          cyc        = 0;
    logic        ack;
    logic [7:0]  d8;

    tw_bus_unit #(.ADDR_W(8)) DUT (
        .ref_clk(ref_clk), .reset_n(reset_n),
        .s_axi_awaddr(aw_a), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
        .s_axi_araddr(ar_a), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
        .p_scl_i(scl), .p_scl_o(), .p_scl_oe(p_scl_oe),
        .p_sda_i(sda), .p_sda_o(), .p_sda_oe(p_sda_oe),
        .s_scl_i(s_scl), .s_scl_o(), .s_scl_oe(s_scl_oe),
        .s_sda_i(s_sda), .s_sda_o(), .s_sda_oe(s_sda_oe)
    );

    tw_master_model m (.scl(scl), .sda(sda), .scl_oe(m_scl), .sda_oe(m_sda));
    // Second master on the secondary pair for dual mode
    tw_master_model m2 (.scl(s_scl), .sda(s_sda), .scl_oe(m2_scl), .sda_oe(m2_sda));

    initial begin
        forever #25 ref_clk = !ref_clk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge ref_clk);
        aw_a <= a;
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (awr) awv <= 1'b0;
            if (wr_r) wv <= 1'b0;
            if (bv) break;
        end
        chk({30'h0, br}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge ref_clk);
        ar_a <= a;
        arv <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        chk(rdat, exp);
        chk({30'h0, rr}, {30'h0, er});
    endtask

    task automatic addr_c(input logic [7:0] a, input logic exp);
        m.tx(a, ack);
        chk({31'h0, ack}, {31'h0, exp});
    endtask

    task automatic final_report;
        $display("Checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic t_setup;
        rd(`TW_OFS_SADDR, 32'h0, `TW_RESP_OK);
        rd(8'h40, 32'h0, `TW_RESP_ERR);
        wr(8'h42, 8'h11, `TW_RESP_ERR);
        wr(`TW_OFS_CTRLA, 8'h00, `TW_RESP_OK);
        wr(`TW_OFS_DUAL, 8'h00, `TW_RESP_OK);
        wr(`TW_OFS_BAUD, 8'h10, `TW_RESP_OK);
        wr(`TW_OFS_MCTRL, 8'h01, `TW_RESP_OK);
        rd(`TW_OFS_MSTAT, 32'h0, `TW_RESP_OK);
        wr(`TW_OFS_SADDR, 8'h54, `TW_RESP_OK);
        rd(`TW_OFS_SADDR, 32'h54, `TW_RESP_OK);
        wr(`TW_OFS_SCTRL, 8'h01, `TW_RESP_OK);
    endtask

    task automatic t_write;
        m.start_c();
        addr_c({7'h2A, 1'b0}, 1'b1);
        m.tx(8'hA5, ack);
        chk({31'h0, ack}, 32'h1);
        // Slave stretches the clock until the byte is read
        rd(`TW_OFS_SDATA, 32'hA5, `TW_RESP_OK);
        m.stop_c();
        rd(`TW_OFS_MSTAT, {30'h0, `TW_BS_FORCE}, `TW_RESP_OK);
        wr(`TW_OFS_MCTRL, 8'h00, `TW_RESP_OK);
        wr(`TW_OFS_MCTRL, 8'h01, `TW_RESP_OK);
        rd(`TW_OFS_MSTAT, 32'h0, `TW_RESP_OK);
        wr(`TW_OFS_MSTAT, {6'h0, `TW_BS_FORCE}, `TW_RESP_OK);
        rd(`TW_OFS_MSTAT, {30'h0, `TW_BS_FORCE}, `TW_RESP_OK);
    endtask

    task automatic t_nomatch;
        m.start_c();
        addr_c({7'h15, 1'b0}, 1'b0);
        m.stop_c();
    endtask

    task automatic t_read;
        wr(`TW_OFS_SDATA, 8'h3C, `TW_RESP_OK);
        m.start_c();
        addr_c({7'h2A, 1'b1}, 1'b1);
        m.rx(d8, 1'b0);
        chk({24'h0, d8}, 32'h3C);
        m.stop_c();
    endtask

    task automatic t_comb;
        wr(`TW_OFS_SDATA, 8'hC3, `TW_RESP_OK);
        m.start_c();
        addr_c({7'h2A, 1'b0}, 1'b1);
        m.tx(8'h5A, ack);
        chk({31'h0, ack}, 32'h1);
        rd(`TW_OFS_SDATA, 32'h5A, `TW_RESP_OK);
        m.start_c();
        addr_c({7'h2A, 1'b1}, 1'b1);
        m.rx(d8, 1'b0);
        chk({24'h0, d8}, 32'hC3);
        m.stop_c();
        rd(`TW_OFS_SSTAT, 32'h73, `TW_RESP_OK);
        wr(`TW_OFS_SSTAT, 8'h7F, `TW_RESP_OK);
        rd(`TW_OFS_SSTAT, 32'h2, `TW_RESP_OK);
    endtask

    task automatic t_dual;
        wr(`TW_OFS_DUAL, 8'h01, `TW_RESP_OK);
        m.start_c();
        addr_c({7'h2A, 1'b0}, 1'b0);
        m.stop_c();
        m2.start_c();
        m2.tx({7'h2A, 1'b0}, ack);
        chk({31'h0, ack}, 32'h1);
        m2.stop_c();
    endtask

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            final_report();
        end
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_setup();
        t_write();
        t_nomatch();
        t_read();
        t_comb();
        t_dual();
        final_report();
    end
endmodule // tw_bus_unit_bench

`default_nettype wire

// *** tb/tw_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module tw_master_model (
    input  wire logic scl,
    input  wire logic sda,
    output var logic  scl_oe,
    output var logic  sda_oe
);
    localparam int Q = 100;

    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end

    ////////////////////////////////////////////////////////////////
    // Release the clock and wait while anyone stretches it
    task automatic rel_scl;
        scl_oe = 1'b0;
        wait (scl === 1'b1);
        #3;
    endtask

    task automatic start_c;
        #3;
        sda_oe = 1'b0;
        #Q;
        rel_scl();
        #Q;
        sda_oe = 1'b1;
        #Q;
        scl_oe = 1'b1;
        #Q;
    endtask

    task automatic stop_c;
        sda_oe = 1'b1;
        #Q;
        rel_scl();
        #Q;
        sda_oe = 1'b0;
        #(2 * Q);
    endtask

    // Data moves halfway into the low phase, sampled mid high
    task automatic bit_c(input logic b, output logic r);
        #Q;
        sda_oe = !b;
        #Q;
        rel_scl();
        #Q;
        r = sda;
        #Q;
        scl_oe = 1'b1;
    endtask

    task automatic tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_c(d[i], r);
        end
        bit_c(1'b1, r);
        ack = !r;
    endtask

    task automatic rx(output logic [7:0] d, input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_c(1'b1, d[i]);
        end
        bit_c(!ack, r);
    endtask
endmodule // tw_master_model

`default_nettype wire
